/* core/octal_xcvr.sv */
// registered octal bus transceiver with boundary-scan test circuitry
// assumes every pin input is asynchronous to i_clk and resynchronised here;
// capture clocks and tck must stay well below i_clk / 4 to be seen.
module octal_xcvr
  import xcvr_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [WIDTH-1:0]  i_a,
  output logic      [WIDTH-1:0]  o_a,
  output logic                   o_a_oe,
  input  wire logic [WIDTH-1:0]  i_b,
  output logic      [WIDTH-1:0]  o_b,
  output logic                   o_b_oe,
  input  wire logic              i_a_to_b_capture_clock,
  input  wire logic              i_b_to_a_capture_clock,
  input  wire logic              i_a_to_b_source_select,
  input  wire logic              i_b_to_a_source_select,
  input  wire logic              i_b_side_drive_enable,
  input  wire logic              i_a_side_drive_enable_n,
  input  wire logic              i_tck,
  input  wire logic              i_tms,
  input  wire logic              i_tdi,
  output logic                   o_tdo,
  output logic                   o_tdo_oe,
  input  wire avs_req_t          i_avs,
  output logic                   o_avs_waitrequest,
  output logic      [31:0]       o_avs_readdata
);

  if (WIDTH != DATA_W) begin : g_width_check
    $error("octal_xcvr: WIDTH must equal DATA_W");
  end

  typedef struct packed {
    pins_t             s1;
    pins_t             s2;
    logic              clk_ab_prev;
    logic              clk_ba_prev;
    logic              tck_prev;
    logic [DATA_W-1:0] ab_store;
    logic [DATA_W-1:0] ba_store;
    logic [DATA_W-1:0] b_out;
    logic [DATA_W-1:0] a_out;
    logic              b_oe;
    logic              a_oe;
    tap_state_t        tap;
    logic [IR_W-1:0]   ir_shift;
    logic [IR_W-1:0]   ir;
    logic [BSR_W-1:0]  bsr_shift;
    logic [BSR_W-1:0]  bsr_upd;
    logic              byp;
    logic [SIG_W-1:0]  sig;
    logic [SIG_W-1:0]  prpg;
    logic              tdo;
    logic              tdo_oe;
    logic [31:0]       ctrl;
    logic [31:0]       rdata;
    logic              rd_done;
  } state_t;

  localparam state_t STATE_RST = '{
    tap: TAP_RESET, ir: OP_BYPASS, ir_shift: IR_CAPTURE,
    s1: '{oe_a_n: 1'b1, default: '0}, s2: '{oe_a_n: 1'b1, default: '0},
    sig: SIG_RST, prpg: PRPG_RST, ctrl: CTRL_RST, default: '0
  };

  state_t q;
  state_t n;

  // pins go to the test logic only under these opcodes
  function automatic logic is_test(input logic [IR_W-1:0] op);
    return (op == OP_EXTEST) || (op == OP_SELFTEST) ||
           (op == OP_PSA) || (op == OP_PRPG);
  endfunction

  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic tms);
    tap_state_t r;
    r = s;
    unique case (s)
      TAP_RESET:    r = tms ? TAP_RESET    : TAP_IDLE;
      TAP_IDLE:     r = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_DR:   r = tms ? TAP_SEL_IR   : TAP_CAP_DR;
      TAP_CAP_DR:   r = tms ? TAP_EX1_DR   : TAP_SHIFT_DR;
      TAP_SHIFT_DR: r = tms ? TAP_EX1_DR   : TAP_SHIFT_DR;
      TAP_EX1_DR:   r = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
      TAP_PAUSE_DR: r = tms ? TAP_EX2_DR   : TAP_PAUSE_DR;
      TAP_EX2_DR:   r = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
      TAP_UPD_DR:   r = tms ? TAP_SEL_DR   : TAP_IDLE;
      TAP_SEL_IR:   r = tms ? TAP_RESET    : TAP_CAP_IR;
      TAP_CAP_IR:   r = tms ? TAP_EX1_IR   : TAP_SHIFT_IR;
      TAP_SHIFT_IR: r = tms ? TAP_EX1_IR   : TAP_SHIFT_IR;
      TAP_EX1_IR:   r = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
      TAP_PAUSE_IR: r = tms ? TAP_EX2_IR   : TAP_PAUSE_IR;
      TAP_EX2_IR:   r = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
      TAP_UPD_IR:   r = tms ? TAP_SEL_DR   : TAP_IDLE;
    endcase
    return r;
  endfunction

  function automatic logic [SIG_W-1:0] lfsr(input logic [SIG_W-1:0] v);
    return {v[SIG_W-2:0], ^(v & SIG_POLY)};
  endfunction

  logic test_on;
  logic ab_edge;
  logic ba_edge;
  logic tck_rise;
  logic tck_fall;
  logic rd_take;

  assign test_on  = is_test(q.ir);
  assign ab_edge  = q.s2.clk_ab & ~q.clk_ab_prev;
  assign ba_edge  = q.s2.clk_ba & ~q.clk_ba_prev;
  assign tck_rise = q.s2.tck & ~q.tck_prev;
  assign tck_fall = ~q.s2.tck & q.tck_prev;
  assign rd_take  = i_avs.read & ~q.rd_done;

  always_comb begin
    n = q;
    n.s1 = '{a: i_a, b: i_b,
             clk_ab: i_a_to_b_capture_clock,
             clk_ba: i_b_to_a_capture_clock,
             sel_ab: i_a_to_b_source_select,
             sel_ba: i_b_to_a_source_select,
             oe_b: i_b_side_drive_enable,
             oe_a_n: i_a_side_drive_enable_n,
             tck: i_tck, tms: i_tms, tdi: i_tdi};
    n.s2 = q.s1;
    n.clk_ab_prev = q.s2.clk_ab;
    n.clk_ba_prev = q.s2.clk_ba;
    n.tck_prev = q.s2.tck;

    if (!test_on) begin
      // capture A data only on its edge
      if (ab_edge) begin
        n.ab_store = q.s2.a;
      end
      if (ba_edge) begin
        n.ba_store = q.s2.b;
      end
      n.b_out = q.s2.sel_ab ? q.ab_store : q.s2.a;
      n.a_out = q.s2.sel_ba ? q.ba_store : q.s2.b;
      n.b_oe = q.s2.oe_b;
      n.a_oe = ~q.s2.oe_a_n;
    end else begin
      // pins handed to test logic; stores frozen meanwhile
      case (q.ir)
        OP_PRPG: begin
          n.a_out = q.prpg[DATA_W-1:0];
          n.b_out = q.prpg[SIG_W-1:DATA_W];
          n.a_oe = 1'b1;
          n.b_oe = 1'b1;
        end
        OP_PSA: begin
          // inputs are compacted, so nothing may drive them
          n.a_oe = 1'b0;
          n.b_oe = 1'b0;
        end
        default: begin
          n.a_out = q.bsr_upd[DATA_W-1:0];
          n.b_out = q.bsr_upd[SIG_W-1:DATA_W];
          n.a_oe = q.bsr_upd[SIG_W];
          n.b_oe = q.bsr_upd[SIG_W+1];
        end
      endcase
    end

    // tap and test registers stepped on tck rise only; tdo and its enable move on tck fall
    if (tck_rise) begin
      n.tap = tap_next(q.tap, q.s2.tms);
      case (q.tap)
        TAP_RESET: begin
          n.ir = OP_BYPASS;
        end
        TAP_IDLE: begin
          if (q.ir == OP_PSA) begin
            n.sig = lfsr(q.sig) ^ ({q.s2.b, q.s2.a} & ~q.ctrl[SIG_W-1:0]);
          end
          if (q.ir == OP_PRPG) begin
            n.prpg = lfsr(q.prpg);
          end
        end
        TAP_CAP_DR: begin
          n.bsr_shift = (q.ir == OP_SELFTEST) ? q.bsr_upd :
                        {q.s2.oe_b, ~q.s2.oe_a_n, q.s2.b, q.s2.a};
          n.byp = 1'b0;
        end
        TAP_SHIFT_DR: begin
          n.bsr_shift = {q.s2.tdi, q.bsr_shift[BSR_W-1:1]};
          n.byp = q.s2.tdi;
        end
        TAP_UPD_DR: begin
          if (q.ir != OP_BYPASS) begin
            n.bsr_upd = q.bsr_shift;
          end
        end
        TAP_CAP_IR: begin
          n.ir_shift = IR_CAPTURE;
        end
        TAP_SHIFT_IR: begin
          n.ir_shift = {q.s2.tdi, q.ir_shift[IR_W-1:1]};
        end
        TAP_UPD_IR: begin
          n.ir = q.ir_shift;
        end
        default: begin
        end
      endcase
    end

    if (tck_fall) begin
      n.tdo_oe = (q.tap == TAP_SHIFT_IR) || (q.tap == TAP_SHIFT_DR);
      if (q.tap == TAP_SHIFT_IR) begin
        n.tdo = q.ir_shift[0];
      end else if (q.tap == TAP_SHIFT_DR) begin
        n.tdo = (q.ir == OP_BYPASS) ? q.byp : q.bsr_shift[0];
      end
    end

    n.rd_done = rd_take;
    if (rd_take) begin
      unique case (i_avs.address)
        OFF_CTRL:  n.rdata = q.ctrl;
        OFF_STORE: n.rdata = {16'h0000, q.ba_store, q.ab_store};
        OFF_SIG:   n.rdata = {16'h0000, q.sig};
        OFF_TAP:   n.rdata = {23'h000000, test_on, q.ir, q.tap};
        default:   n.rdata = 32'h0000_0000;
      endcase
    end
    if (i_avs.write && i_avs.address == OFF_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (i_avs.byteenable[i]) begin
          n.ctrl[8*i +: 8] = i_avs.writedata[8*i +: 8];
        end
      end
      n.ctrl = n.ctrl & CTRL_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign o_a               = q.a_out;
  assign o_a_oe            = q.a_oe;
  assign o_b               = q.b_out;
  assign o_b_oe            = q.b_oe;
  assign o_tdo             = q.tdo;
  assign o_tdo_oe          = q.tdo_oe;
  assign o_avs_readdata    = q.rdata;
  assign o_avs_waitrequest = rd_take;

  sequence s_ab_cap;
    ab_edge && !test_on;
  endsequence

  sequence s_ba_cap;
    ba_edge && !test_on;
  endsequence

  property p_cap_ab;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_ab_cap |=> q.ab_store == $past(q.s2.a);
  endproperty
  a_cap_ab: assert property (p_cap_ab)
    else $error("a-to-b store missed its capture");

  property p_live_ab;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!test_on && !q.s2.sel_ab) |=> o_b == $past(q.s2.a);
  endproperty
  a_live_ab: assert property (p_live_ab)
    else $error("b outputs not showing live a data");

  property p_stored_ab;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!test_on && q.s2.sel_ab) |=> o_b == $past(q.ab_store);
  endproperty
  a_stored_ab: assert property (p_stored_ab)
    else $error("b outputs not showing stored a data");

  property p_b_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!test_on && q.s2.oe_b) |=> o_b_oe;
  endproperty
  a_b_drive: assert property (p_b_drive)
    else $error("b side not driven while enabled");

  property p_b_float;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!test_on && !q.s2.oe_b) |=> !o_b_oe;
  endproperty
  a_b_float: assert property (p_b_float)
    else $error("b side driven while disabled");

  property p_cap_ba;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_ba_cap |=> q.ba_store == $past(q.s2.b);
  endproperty
  a_cap_ba: assert property (p_cap_ba)
    else $error("b-to-a store missed its capture");

  property p_a_enable;
    @(posedge i_clk) disable iff (!i_rst_n)
    !test_on |=> o_a_oe == !$past(q.s2.oe_a_n);
  endproperty
  a_a_enable: assert property (p_a_enable)
    else $error("a side enable polarity wrong");

  property p_test_prpg;
    @(posedge i_clk) disable iff (!i_rst_n)
    (q.ir == OP_PRPG) |=> o_b_oe && o_a_oe && o_b == $past(q.prpg[15:8]);
  endproperty
  a_test_prpg: assert property (p_test_prpg)
    else $error("pattern generator not on the pins");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    !(ab_edge && !test_on) |=> $stable(q.ab_store);
  endproperty
  a_hold: assert property (p_hold)
    else $error("a-to-b store changed without a capture edge");

  property p_tdo_fall;
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(o_tdo_oe) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo enable moved away from a tck fall");

endmodule // octal_xcvr

/* core/xcvr_pkg.sv */
// constants, types and carriers for the registered octal bus transceiver
// assumes a single 200 MHz system clock and an Avalon-MM register master
package xcvr_pkg;

  localparam int DATA_W = 8;
  localparam int IR_W   = 4;
  localparam int SIG_W  = 2 * DATA_W;
  localparam int BSR_W  = 2 * DATA_W + 2;

  // register byte offsets
  localparam logic [3:0] OFF_CTRL  = 4'h0;
  localparam logic [3:0] OFF_STORE = 4'h4;
  localparam logic [3:0] OFF_SIG   = 4'h8;
  localparam logic [3:0] OFF_TAP   = 4'hC;

  // control register: psa input mask in the low half, rest reads zero
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FFFF;

  // instruction opcodes
  localparam logic [IR_W-1:0] OP_EXTEST   = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE   = 4'h2;
  localparam logic [IR_W-1:0] OP_SELFTEST = 4'h3;
  localparam logic [IR_W-1:0] OP_PSA      = 4'h4;
  localparam logic [IR_W-1:0] OP_PRPG     = 4'h5;
  localparam logic [IR_W-1:0] OP_BYPASS   = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

  localparam logic [SIG_W-1:0] SIG_POLY = 16'hD008;
  localparam logic [SIG_W-1:0] SIG_RST  = 16'h0000;
  localparam logic [SIG_W-1:0] PRPG_RST = 16'hACE1;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
    TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [3:0]        address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } avs_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic              clk_ab;
    logic              clk_ba;
    logic              sel_ab;
    logic              sel_ba;
    logic              oe_b;
    logic              oe_a_n;
    logic              tck;
    logic              tms;
    logic              tdi;
  } pins_t;

endpackage : xcvr_pkg

/* sim/bus_partner.sv */
// far-side model of one parallel bus of the transceiver
// assumes the bench never lets both ends drive the bus together
module bus_partner
  import xcvr_pkg::*;
(
  input  wire logic              i_dev_oe,
  input  wire logic [DATA_W-1:0] i_dev,
  input  wire logic              i_far_en,
  input  wire logic [DATA_W-1:0] i_far,
  output logic      [DATA_W-1:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] last;
  always @(o_wire) if (i_dev_oe || i_far_en) last = o_wire;
  // an undriven bus shows the inverse of its last level, so no stale hold
  always_comb begin
    if (i_dev_oe) o_wire = i_dev;
    else if (i_far_en) o_wire = i_far;
    else o_wire = ~last;
  end
endmodule // bus_partner

/* sim/tb_top.sv */
// self-checking bench for the octal transceiver
// assumes bus partners on both pin sides and an Avalon-MM master here
module tb_top
  import xcvr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [DATA_W-1:0] a_far, b_far, wa, wb, o_a, o_b, st_ab, st_ba, ea, eb, xa;
  logic              a_en, b_en, o_a_oe, o_b_oe, ckab, ckba, a_to_b_source_select, b_to_a_source_select;
  logic              oeb, oean, tck, tms, tdi, o_tdo, o_tdo_oe, o_wr, pt;
  logic [31:0]       o_rd, rd, r;
  logic [SIG_W-1:0]  s;
  logic [BSR_W-1:0]  sv;
  avs_req_t          avs;
  int                fails = 0, n_tests = 0, seed = 58891, i;

  always #2.5 i_clk = ~i_clk;

  octal_xcvr DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_a(wa), .o_a(o_a),
    .o_a_oe(o_a_oe), .i_b(wb), .o_b(o_b), .o_b_oe(o_b_oe),
    .i_a_to_b_capture_clock(ckab), .i_b_to_a_capture_clock(ckba),
    .i_a_to_b_source_select(a_to_b_source_select), .i_b_to_a_source_select(b_to_a_source_select),
    .i_b_side_drive_enable(oeb), .i_a_side_drive_enable_n(oean),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .i_avs(avs), .o_avs_waitrequest(o_wr),
    .o_avs_readdata(o_rd));
  bus_partner pa (.i_dev_oe(o_a_oe), .i_dev(o_a), .i_far_en(a_en),
    .i_far(a_far), .o_wire(wa));
  bus_partner pb (.i_dev_oe(o_b_oe), .i_dev(o_b), .i_far_en(b_en),
    .i_far(b_far), .o_wire(wb));

  task automatic print_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // request held until an edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] wd);
    @(posedge i_clk);
    avs <= '{read: !wr, write: wr, address: ad, writedata: wd,
             byteenable: 4'hF};
    // only the watchdog ends a wait that never sees waitrequest low
    do @(posedge i_clk); while (o_wr !== 1'b0);
    rd = o_rd;
    avs <= '0;
  endtask

  // signature register: shift left, feedback is parity of the tapped bits
  function automatic logic [SIG_W-1:0] sig_step(input logic [SIG_W-1:0] v,
                                                input logic [SIG_W-1:0] d);
    return {v[SIG_W-2:0], ^(v & SIG_POLY)} ^ d;
  endfunction

  task automatic tstep(input logic m, input logic d);
    @(posedge i_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge i_clk);
    tck <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  // from reset, idle or update state: shift ir lsb first, back to idle
  task automatic load_ir(input logic [3:0] op);
    logic [10:0] m;
    m = 11'h306;
    for (int k = 0; k < 11; k++)
      tstep(m[k], (k >= 5 && k <= 8) ? op[k-5] : 1'b0);
  endtask

  task automatic pulse(input logic ab);
    @(posedge i_clk);
    if (ab) ckab <= 1'b1;
    else ckba <= 1'b1;
    repeat (4) @(posedge i_clk);
    ckab <= 1'b0;
    ckba <= 1'b0;
    cyc(6);
  endtask

  // a side is driven by the device only while the b side floats
  function automatic void model();
    ea = b_to_a_source_select ? st_ba : b_far;
    xa = oean ? a_far : ea;
    eb = a_to_b_source_select ? st_ab : xa;
  endfunction

  initial begin
    a_far = '0; b_far = '0; a_en = 1'b1; b_en = 1'b1;
    ckab = 1'b0; ckba = 1'b0; a_to_b_source_select = 1'b0; b_to_a_source_select = 1'b0;
    oeb = 1'b0; oean = 1'b1; tck = 1'b0; tms = 1'b1; tdi = 1'b0;
    avs = '0; st_ab = '0; st_ba = '0; pt = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, OFF_CTRL, '0);
    chk(rd, CTRL_RST); // reset value
    bus(1'b1, OFF_CTRL, '1);
    bus(1'b0, OFF_CTRL, '0);
    chk(rd, CTRL_MASK); // mask width
    bus(1'b1, OFF_STORE, '1);
    bus(1'b0, OFF_STORE, '0);
    chk(rd, '0); // stores untouched by writes
    bus(1'b0, 4'h2, '0);
    chk(rd, '0); // unmapped read
    tstep(1'b0, 1'b0);
    tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0);
    tstep(1'b0, 1'b0);
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      @(posedge i_clk);
      a_far <= r[7:0];
      b_far <= r[15:8];
      a_to_b_source_select <= r[16];
      b_to_a_source_select <= r[17];
      oeb <= r[18];
      oean <= r[18] | r[19];
      a_en <= r[18] | r[19];
      b_en <= ~r[18];
      tstep(1'b0, r[23]);
      cyc(6);
      model;
      if (r[20]) begin
        pulse(1'b1);
        st_ab = xa;
        model;
      end
      if (r[21]) begin
        pulse(1'b0);
        st_ba = oeb ? eb : b_far;
        model;
      end
      chk(32'(o_b_oe), 32'(r[18])); // drive enable
      chk(32'(o_a_oe), 32'(!(r[18] | r[19]))); // low enable
      if (r[18]) chk(32'(o_b), 32'(eb)); // b data
      else if (!r[19]) chk(32'(o_a), 32'(ea)); // a data
      chk(32'(o_tdo_oe), 32'd1); // tdo driven in shift
      chk(32'(o_tdo), 32'(pt)); // bypass bit one step late
      pt = r[23];
      bus(1'b0, OFF_STORE, '0);
      chk(rd, {16'h0, st_ba, st_ab}); // capture and hold
    end
    tstep(1'b1, 1'b0);
    tstep(1'b1, 1'b0);
    load_ir(OP_EXTEST);
    bus(1'b0, OFF_TAP, '0);
    chk(rd, {23'h0, 1'b1, OP_EXTEST, TAP_IDLE}); // test entry
    @(posedge i_clk);
    a_far <= ~st_ab;
    b_far <= ~st_ba;
    oean <= 1'b1;
    oeb <= 1'b0;
    a_en <= 1'b1;
    b_en <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    bus(1'b0, OFF_STORE, '0);
    chk(rd, {16'h0, st_ba, st_ab}); // stores frozen
    // A half masked, so only the B wire folds into the signature
    bus(1'b1, OFF_CTRL, 32'h0000_00FF);
    load_ir(OP_PSA);
    s = '0;
    for (i = 0; i < 4; i++) begin
      tstep(1'b0, 1'b0);
      s = sig_step(s, {b_far, a_far} & 16'hFF00);
    end
    bus(1'b0, OFF_SIG, '0);
    chk(rd, {16'h0, s}); // masked signature
    @(posedge i_clk);
    a_en <= 1'b0;
    b_en <= 1'b0;
    load_ir(OP_PRPG);
    cyc(2);
    chk(32'({o_a_oe, o_b_oe, o_b, o_a}), 32'({2'b11, PRPG_RST}));
    tstep(1'b0, 1'b0);
    cyc(2);
    chk(32'({o_b, o_a}), 32'(sig_step(PRPG_RST, '0))); // next pattern
    for (i = 0; i < 5; i++) tstep(1'b1, 1'b0);
    @(posedge i_clk);
    a_to_b_source_select <= 1'b0;
    oeb <= 1'b1;
    b_en <= 1'b0;
    a_en <= 1'b1;
    cyc(6);
    chk(32'(o_b), 32'(a_far)); // normal again
    // snapshot: enables then both wires, shifted out lsb first
    load_ir(OP_SAMPLE);
    tstep(1'b1, 1'b0);
    tstep(1'b0, 1'b0);
    tstep(1'b0, 1'b0);
    sv = {1'b1, 1'b0, a_far, a_far};
    for (i = 0; i < BSR_W; i++) begin
      tstep(1'b0, 1'b0);
      chk(32'(o_tdo), 32'(sv[i])); // pin snapshot
    end
    cyc(1);
    chk(32'(o_b), 32'(a_far)); // sampling leaves pins alone
    print_verdict;
  end

  initial begin
    repeat (40000) @(posedge i_clk);
    fails++;
    print_verdict;
  end
endmodule // tb_top
